// [hdl/pll_cfg_pkg.sv]
/*
 * Constants, field positions and types shared by the synthesizer control logic.
 * Assumes a single 40 MHz system clock and a classic Wishbone register master.
 */
package pll_cfg_pkg;
    localparam int CLK_MHZ = 40;
    localparam int LOCK_TIGHT_NS = 15;
    localparam int LOCK_LOOSE_NS = 25;
    // Tight bound rounds down (longest), loose bound also a longest time
    localparam int TIGHT_RAW = (LOCK_TIGHT_NS * CLK_MHZ) / 1000;
    localparam int LOOSE_RAW = (LOCK_LOOSE_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] LOCK_TIGHT_CYC = 8'((TIGHT_RAW < 1) ? 1 : TIGHT_RAW);
    localparam logic [7:0] LOCK_LOOSE_CYC = 8'((LOOSE_RAW < 1) ? 1 : LOOSE_RAW);
    localparam logic [2:0] LOCK_NEED_NORMAL = 3'h3;
    localparam logic [2:0] LOCK_NEED_PRECISE = 3'h5;

    localparam int WORD_W = 24;
    localparam int REF_W = 14;
    localparam int FB_W = 13;
    // Latch select codes in the two word LSBs
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_FB = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;
    // Field positions
    localparam int REF_LSB = 2;
    localparam int FB_LSB = 8;
    localparam int LOCK_PREC_POS = 20;
    localparam int PDOWN_POS = 7;
    localparam int PUMP_TRI_POS = 8;
    localparam int OBS_LSB = 4;
    // Observation select codes
    localparam logic [2:0] OBS_LOW = 3'h0;
    localparam logic [2:0] OBS_LOCK = 3'h1;
    localparam logic [2:0] OBS_FB_DIV = 3'h2;
    localparam logic [2:0] OBS_REF_DIV = 3'h4;
    // Wishbone register byte offsets
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_CTRL = 5'h04;
    localparam logic [4:0] REG_REF_LATCH = 5'h08;
    localparam logic [4:0] REG_FB_LATCH = 5'h0C;
    localparam logic [4:0] REG_FUNC_LATCH = 5'h10;
    localparam logic [4:0] REG_INIT_LATCH = 5'h14;
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    localparam logic CTRL_HOLD_RESET = 1'b0;

    typedef enum logic [2:0] {
        PFD_IDLE = 3'b001,
        PFD_UP = 3'b010,
        PFD_DN = 3'b100
    } pfd_state_e;

    typedef struct packed {
        logic [23:0] ref_word;
        logic [23:0] fb_word;
        logic [23:0] func_word;
        logic [23:0] init_word;
    } latch_set_s;
endpackage : pll_cfg_pkg

// [hdl/pll_divider_serial_config.sv]
/*
 * Digital core of the PLL synthesizer: three-wire serial programming port,
 * four configuration latches, reference and feedback dividers, phase detector,
 * digital lock detect, power-down control and observation multiplexer.
 * Assumes all pins are asynchronous to clk_i and change slower than two clk_i periods.
 */
// Functional notes
// - Enable pin low powers down and tri-states the pump output.
// - Enable pin high powers up only if powerdown bit is clear.
// - Serial data shifts into 24-bit register on each serial clock rising edge.
// - Load strobe rising edge copies shift register into selected latch.
// - Observation output shows lock, divided feedback or divided reference.
// - Feedback divider is 13-bit, ratios 1 through 8191.
// - Reference divider is 14-bit, ratios 1 through 16383.
// - Reference divider output clocks the phase detector reference side.
// - Feedback divider output clocks the phase detector feedback side.
// - Power-down closes the reference input switch, leaving reference unloaded.
// - Word bits 1:0 pick reference, feedback, function or initialization latch.
// - Three-bit field in the function latch chooses the observation source.
// - Lock after 3 or 5 cycles under 15 ns, lost above 25 ns.
module pll_divider_serial_config
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic load_strobe_i,
    input wire logic chip_enable_i,
    input wire logic reference_clock_in_i,
    input wire logic rf_feedback_in_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic pump_up_o,
    output logic pump_dn_o,
    output logic pump_output_oe_o,
    output logic reference_input_switch_o,
    output logic observation_output_o,
    output logic lock_detect_o
);
    logic [2:0] sclk_sync_ff;
    logic [1:0] sdata_sync_ff;
    logic [2:0] le_sync_ff;
    logic [1:0] ce_sync_ff;
    logic [2:0] ref_sync_ff;
    logic [2:0] rf_sync_ff;
    logic [pll_cfg_pkg::WORD_W-1:0] shift_ff;
    pll_cfg_pkg::latch_set_s latch_ff;
    logic ctrl_hold_ff;
    logic powered_ff;
    logic [pll_cfg_pkg::REF_W-1:0] ref_cnt_ff;
    logic [pll_cfg_pkg::FB_W-1:0] fb_cnt_ff;
    logic ref_pulse_ff;
    logic fb_pulse_ff;
    logic ref_div_ff;
    logic fb_div_ff;
    pll_cfg_pkg::pfd_state_e pfd_ff;
    pll_cfg_pkg::pfd_state_e nxt_pfd;
    logic [7:0] err_cnt_ff;
    logic done_ff;
    logic [7:0] done_err_ff;
    logic [2:0] good_cnt_ff;
    logic lock_ff;
    logic [2:0] obs_sel;
    logic [2:0] lock_need;
    logic ref_edge;
    logic rf_edge;
    logic sclk_rise;
    logic le_rise;
    logic dividers_run;
    logic wb_req;
    logic [31:0] rd_data;

    // Next count of a down-counting divider; a ratio of zero acts as one
    function automatic logic [13:0] div_next(input logic [13:0] cnt, input logic [13:0] ratio);
        logic [13:0] res;
        res = cnt - 14'h0001;
        if (cnt <= 14'h0001)
        begin
            res = (ratio == 14'h0000) ? 14'h0001 : ratio;
        end
        return res;
    endfunction

    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    assign le_rise = le_sync_ff[1] & ~le_sync_ff[2];
    assign ref_edge = ref_sync_ff[1] & ~ref_sync_ff[2];
    assign rf_edge = rf_sync_ff[1] & ~rf_sync_ff[2];
    assign dividers_run = powered_ff & ~ctrl_hold_ff;
    assign obs_sel = latch_ff.func_word[pll_cfg_pkg::OBS_LSB +: 3];
    assign lock_need = latch_ff.ref_word[pll_cfg_pkg::LOCK_PREC_POS] ?
        pll_cfg_pkg::LOCK_NEED_PRECISE : pll_cfg_pkg::LOCK_NEED_NORMAL;
    assign wb_req = wb_cyc_i & wb_stb_i;

    // Pin synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_sync_ff <= 3'h0;
            sdata_sync_ff <= 2'h0;
            le_sync_ff <= 3'h0;
            ce_sync_ff <= 2'h0;
            ref_sync_ff <= 3'h0;
            rf_sync_ff <= 3'h0;
        end
        else
        begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk_i};
            sdata_sync_ff <= {sdata_sync_ff[0], serial_data_i};
            le_sync_ff <= {le_sync_ff[1:0], load_strobe_i};
            ce_sync_ff <= {ce_sync_ff[0], chip_enable_i};
            ref_sync_ff <= {ref_sync_ff[1:0], reference_clock_in_i};
            rf_sync_ff <= {rf_sync_ff[1:0], rf_feedback_in_i};
        end
    end

    // Serial shift register, MSB arrives first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shift_ff <= pll_cfg_pkg::LATCH_RESET;
        end
        else if (sclk_rise)
        begin
            shift_ff <= {shift_ff[pll_cfg_pkg::WORD_W-2:0], sdata_sync_ff[1]};
        end
    end

    // Latch transfer; nothing changes without a load strobe edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            latch_ff <= {4{pll_cfg_pkg::LATCH_RESET}};
        end
        else if (le_rise)
        begin
            unique case (shift_ff[1:0])
                pll_cfg_pkg::SEL_REF: latch_ff.ref_word <= shift_ff;
                pll_cfg_pkg::SEL_FB: latch_ff.fb_word <= shift_ff;
                pll_cfg_pkg::SEL_FUNC: latch_ff.func_word <= shift_ff;
                pll_cfg_pkg::SEL_INIT:
                begin
                    // Initialization word also sets the function fields
                    latch_ff.init_word <= shift_ff;
                    latch_ff.func_word <= shift_ff;
                end
            endcase
        end
    end

    // Power state and reference input switch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            powered_ff <= 1'b0;
            reference_input_switch_o <= 1'b1;
        end
        else
        begin
            powered_ff <= ce_sync_ff[1] & ~latch_ff.func_word[pll_cfg_pkg::PDOWN_POS];
            reference_input_switch_o <= ~(ce_sync_ff[1] & ~latch_ff.func_word[pll_cfg_pkg::PDOWN_POS]);
        end
    end

    // Reference divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_cnt_ff <= 14'h0001;
            ref_pulse_ff <= 1'b0;
            ref_div_ff <= 1'b0;
        end
        else if (!dividers_run)
        begin
            ref_cnt_ff <= 14'h0001;
            ref_pulse_ff <= 1'b0;
            ref_div_ff <= 1'b0;
        end
        else
        begin
            ref_pulse_ff <= 1'b0;
            if (ref_edge)
            begin
                ref_cnt_ff <= div_next(ref_cnt_ff,
                    latch_ff.ref_word[pll_cfg_pkg::REF_LSB +: pll_cfg_pkg::REF_W]);
                ref_pulse_ff <= (ref_cnt_ff <= 14'h0001);
                if (ref_cnt_ff <= 14'h0001)
                begin
                    ref_div_ff <= ~ref_div_ff;
                end
            end
        end
    end

    // Feedback divider
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fb_cnt_ff <= 13'h0001;
            fb_pulse_ff <= 1'b0;
            fb_div_ff <= 1'b0;
        end
        else if (!dividers_run)
        begin
            fb_cnt_ff <= 13'h0001;
            fb_pulse_ff <= 1'b0;
            fb_div_ff <= 1'b0;
        end
        else
        begin
            fb_pulse_ff <= 1'b0;
            if (rf_edge)
            begin
                // Ratio field is 13 bits wide, so the top result bit is always zero
                fb_cnt_ff <= 13'(div_next({1'b0, fb_cnt_ff},
                    {1'b0, latch_ff.fb_word[pll_cfg_pkg::FB_LSB +: pll_cfg_pkg::FB_W]}));
                fb_pulse_ff <= (fb_cnt_ff <= 13'h0001);
                if (fb_cnt_ff <= 13'h0001)
                begin
                    fb_div_ff <= ~fb_div_ff;
                end
            end
        end
    end

    // Phase detector state
    always_comb
    begin
        nxt_pfd = pfd_ff;
        unique case (pfd_ff)
            pll_cfg_pkg::PFD_IDLE:
            begin
                if (ref_pulse_ff && !fb_pulse_ff)
                begin
                    nxt_pfd = pll_cfg_pkg::PFD_UP;
                end
                else if (fb_pulse_ff && !ref_pulse_ff)
                begin
                    nxt_pfd = pll_cfg_pkg::PFD_DN;
                end
            end
            pll_cfg_pkg::PFD_UP:
            begin
                if (fb_pulse_ff)
                begin
                    nxt_pfd = pll_cfg_pkg::PFD_IDLE;
                end
            end
            pll_cfg_pkg::PFD_DN:
            begin
                if (ref_pulse_ff)
                begin
                    nxt_pfd = pll_cfg_pkg::PFD_IDLE;
                end
            end
            default: nxt_pfd = pll_cfg_pkg::PFD_IDLE;
        endcase
        if (!powered_ff)
        begin
            nxt_pfd = pll_cfg_pkg::PFD_IDLE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pfd_ff <= pll_cfg_pkg::PFD_IDLE;
            pump_up_o <= 1'b0;
            pump_dn_o <= 1'b0;
            pump_output_oe_o <= 1'b0;
        end
        else
        begin
            pfd_ff <= nxt_pfd;
            pump_up_o <= (nxt_pfd == pll_cfg_pkg::PFD_UP);
            pump_dn_o <= (nxt_pfd == pll_cfg_pkg::PFD_DN);
            pump_output_oe_o <= powered_ff & ~latch_ff.func_word[pll_cfg_pkg::PUMP_TRI_POS];
        end
    end

    // Phase error measured in clk_i cycles, saturating
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_cnt_ff <= 8'h00;
            done_ff <= 1'b0;
            done_err_ff <= 8'h00;
        end
        else
        begin
            done_ff <= 1'b0;
            if (pfd_ff == pll_cfg_pkg::PFD_IDLE)
            begin
                err_cnt_ff <= 8'h01;
                done_ff <= ref_pulse_ff & fb_pulse_ff & powered_ff;
                done_err_ff <= 8'h00;
            end
            else if (nxt_pfd == pll_cfg_pkg::PFD_IDLE)
            begin
                done_ff <= powered_ff;
                done_err_ff <= err_cnt_ff;
            end
            else if (err_cnt_ff != 8'hFF)
            begin
                err_cnt_ff <= err_cnt_ff + 8'h01;
            end
        end
    end

    // Digital lock detect
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            good_cnt_ff <= 3'h0;
            lock_ff <= 1'b0;
        end
        else if (!powered_ff)
        begin
            good_cnt_ff <= 3'h0;
            lock_ff <= 1'b0;
        end
        else if (done_ff)
        begin
            if (done_err_ff < pll_cfg_pkg::LOCK_TIGHT_CYC)
            begin
                if (good_cnt_ff != 3'h7)
                begin
                    good_cnt_ff <= good_cnt_ff + 3'h1;
                end
                if (good_cnt_ff + 3'h1 >= lock_need)
                begin
                    lock_ff <= 1'b1;
                end
            end
            else if (done_err_ff > pll_cfg_pkg::LOCK_LOOSE_CYC || !lock_ff)
            begin
                good_cnt_ff <= 3'h0;
                lock_ff <= 1'b0;
            end
        end
    end

    // Observation multiplexer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            observation_output_o <= 1'b0;
            lock_detect_o <= 1'b0;
        end
        else
        begin
            lock_detect_o <= lock_ff;
            unique case (obs_sel)
                pll_cfg_pkg::OBS_LOCK: observation_output_o <= lock_ff;
                pll_cfg_pkg::OBS_FB_DIV: observation_output_o <= fb_div_ff;
                pll_cfg_pkg::OBS_REF_DIV: observation_output_o <= ref_div_ff;
                default: observation_output_o <= 1'b0;
            endcase
        end
    end

    // Wishbone read mux; unmapped offsets read zero
    always_comb
    begin
        rd_data = 32'h00000000;
        unique case (wb_adr_i[4:0])
            pll_cfg_pkg::REG_STATUS: rd_data = {29'h0, ~reference_input_switch_o, powered_ff, lock_ff};
            pll_cfg_pkg::REG_CTRL: rd_data = {31'h0, ctrl_hold_ff};
            pll_cfg_pkg::REG_REF_LATCH: rd_data = {8'h00, latch_ff.ref_word};
            pll_cfg_pkg::REG_FB_LATCH: rd_data = {8'h00, latch_ff.fb_word};
            pll_cfg_pkg::REG_FUNC_LATCH: rd_data = {8'h00, latch_ff.func_word};
            pll_cfg_pkg::REG_INIT_LATCH: rd_data = {8'h00, latch_ff.init_word};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Wishbone slave: one wait state, ack for any address
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_hold_ff <= pll_cfg_pkg::CTRL_HOLD_RESET;
        end
        else
        begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o)
            begin
                wb_dat_o <= rd_data;
                if (wb_we_i && wb_sel_i[0] && wb_adr_i[4:0] == pll_cfg_pkg::REG_CTRL)
                begin
                    ctrl_hold_ff <= wb_dat_i[0];
                end
            end
        end
    end
endmodule // pll_divider_serial_config

// [verification/host_serial_model.sv]
/*
 * Host model driving the three-wire programming port.
 * Assumes the bench clock; pins change only after its rising edge.
 */
module host_serial_model
(
    input wire logic clk_i,
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic load_strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    // Phases of 3 clk stay clear of the 2 clk synchroniser limit
    task automatic send_word(input logic [23:0] w, input logic strobe);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk_i) serial_data_o <= w[i];
            repeat (3) @(posedge clk_i);
            serial_clk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            serial_clk_o <= 1'b0;
            // Hold over: line no longer shows the bit
            serial_data_o <= ~w[i];
            repeat (2) @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
        load_strobe_o <= strobe;
        repeat (3) @(posedge clk_i);
        load_strobe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // host_serial_model

// [verification/pll_cfg_sva.sv]
/*
 * Checker for the synthesizer control core, bound to its top module.
 * Assumes one clock and synchronous active-high reset.
 */
module pll_cfg_sva
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_enable_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pump_up_o,
    input wire logic pump_dn_o,
    input wire logic pump_output_oe_o,
    input wire logic reference_input_switch_o,
    input wire logic lock_detect_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Six cycles covers pin synchroniser plus output register
    sequence s_down;
        !chip_enable_i [*6];
    endsequence
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_state: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !pump_output_oe_o
        && reference_input_switch_o && !lock_detect_o)
        else $error("outputs wrong after reset");
    a_down_tristate: assert property (s_down |-> !pump_output_oe_o)
        else $error("pump driven while disabled");
    a_down_pump_idle: assert property (s_down |-> !pump_up_o && !pump_dn_o && !lock_detect_o)
        else $error("detector active while disabled");
    a_down_unloaded: assert property (s_down |-> reference_input_switch_o)
        else $error("reference switch open while disabled");
    a_lock_powered: assert property ($rose(lock_detect_o) |-> !reference_input_switch_o)
        else $error("lock rose while powered down");
    a_pfd_exclusive: assert property (!(pump_up_o && pump_dn_o))
        else $error("pump up and down together");
endmodule // pll_cfg_sva

bind pll_divider_serial_config pll_cfg_sva chk (.clk_i(clk_i), .rst_i(rst_i), .chip_enable_i(chip_enable_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pump_up_o(pump_up_o),
    .pump_dn_o(pump_dn_o), .pump_output_oe_o(pump_output_oe_o),
    .reference_input_switch_o(reference_input_switch_o), .lock_detect_o(lock_detect_o));

// [verification/pll_divider_serial_config_tb.sv]
/*
 * Bench for the synthesizer control core: latch loads, power control, dividers, lock.
 * Assumes the host model on the serial pins and the checker bound from its file.
 */
module pll_divider_serial_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b0;
    logic [1:0] pin = 2'h0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic [31:0] rdat;
    logic [31:0] junk;
    logic ack, up, dn, oe, sw, obs, lock, sclk, sdat, strobe;
    logic obs_q = 1'b0;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int obs_n = 0;
    pll_divider_serial_config dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .serial_data_i(sdat),
        .load_strobe_i(strobe), .chip_enable_i(ce), .reference_clock_in_i(pin[0]), .rf_feedback_in_i(pin[1]),
        .wb_adr_i({27'h0, adr}), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .pump_up_o(up), .pump_dn_o(dn),
        .pump_output_oe_o(oe), .reference_input_switch_o(sw), .observation_output_o(obs),
        .lock_detect_o(lock));
    host_serial_model host (.clk_i(clk_i), .serial_clk_o(sclk), .serial_data_o(sdat), .load_strobe_o(strobe));
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        obs_q <= obs;
        if (obs !== obs_q)
            obs_n <= obs_n + 1;
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] mask, input string what);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(what, exp, r & mask);
    endtask
    task automatic pins(input int n, input logic [1:0] which);
        repeat (n)
        begin
            @(posedge clk_i) pin <= which;
            repeat (2) @(posedge clk_i);
            @(posedge clk_i) pin <= 2'h0;
            repeat (2) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask
    // Power cycling restarts both dividers from a known phase
    task automatic power_cycle();
        @(posedge clk_i) ce <= 1'b0;
        repeat (8) @(posedge clk_i);
        ce <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic div_count(input logic [1:0] which, input int exp, input string what);
        int c0;
        power_cycle();
        c0 = obs_n;
        pins(24, which);
        check(what, 32'(exp), 32'(obs_n - c0));
    endtask
    task automatic t_bus();
        check("switch", 32'h1, {31'h0, sw});
        check("pump enable", 32'h0, {31'h0, oe});
        rd(5'h1C, 32'h0, 32'hFFFFFFFF, "unmapped");
        wb(1'b1, pll_cfg_pkg::REG_CTRL, 32'h1, junk);
        rd(pll_cfg_pkg::REG_CTRL, 32'h1, 32'hFFFFFFFF, "ctrl");
        wb(1'b1, pll_cfg_pkg::REG_CTRL, 32'h0, junk);
        wb(1'b1, pll_cfg_pkg::REG_STATUS, 32'h7, junk);
        rd(pll_cfg_pkg::REG_STATUS, 32'h0, 32'hFFFFFFFF, "status down");
    endtask
    task automatic t_latches();
        logic [23:0] w [4];
        for (int s = 0; s < 4; s++)
        begin
            w[s] = {4'(s), 12'h53C, 6'h15, 2'(s)};
            host.send_word(w[s], 1'b1);
        end
        rd(pll_cfg_pkg::REG_REF_LATCH, {8'h0, w[0]}, 32'hFFFFFFFF, "ref latch");
        rd(pll_cfg_pkg::REG_FB_LATCH, {8'h0, w[1]}, 32'hFFFFFFFF, "fb latch");
        rd(pll_cfg_pkg::REG_FUNC_LATCH, {8'h0, w[3]}, 32'hFFFFFFFF, "func latch");
        rd(pll_cfg_pkg::REG_INIT_LATCH, {8'h0, w[3]}, 32'hFFFFFFFF, "init latch");
        host.send_word(24'hFFFFFE, 1'b0);
        rd(pll_cfg_pkg::REG_FUNC_LATCH, {8'h0, w[3]}, 32'hFFFFFFFF, "func held");
    endtask
    task automatic t_power();
        host.send_word(24'h000022, 1'b1);
        ce <= 1'b1;
        repeat (8) @(posedge clk_i);
        rd(pll_cfg_pkg::REG_STATUS, 32'h2, 32'h3, "status up");
        check("switch up", 32'h0, {31'h0, sw});
        check("pump up", 32'h1, {31'h0, oe});
        host.send_word(24'h0000A2, 1'b1);
        rd(pll_cfg_pkg::REG_STATUS, 32'h0, 32'h3, "status pdown bit");
        check("switch pdown", 32'h1, {31'h0, sw});
    endtask
    task automatic t_divider();
        wb(1'b1, pll_cfg_pkg::REG_CTRL, 32'h1, junk);
        host.send_word(24'h000301, 1'b1);
        host.send_word(24'h000022, 1'b1);
        div_count(2'b10, 0, "held divider");
        wb(1'b1, pll_cfg_pkg::REG_CTRL, 32'h0, junk);
        div_count(2'b10, 8, "fb ratio 3");
        host.send_word(24'h000101, 1'b1);
        div_count(2'b10, 24, "fb ratio 1");
        host.send_word(24'h00000C, 1'b1);
        host.send_word(24'h000042, 1'b1);
        div_count(2'b01, 8, "ref ratio 3");
    endtask
    task automatic t_lock();
        host.send_word(24'h000004, 1'b1);
        host.send_word(24'h000012, 1'b1);
        power_cycle();
        pins(4, 2'b11);
        check("lock", 32'h1, {31'h0, lock});
        check("obs lock", 32'h1, {31'h0, obs});
        pins(1, 2'b01);
        check("pfd up", 32'h1, {31'h0, up});
        pins(1, 2'b10);
        check("lock lost", 32'h0, {31'h0, lock});
        check("pfd idle", 32'h0, {30'h0, up, dn});
        pins(1, 2'b10);
        check("pfd down", 32'h1, {31'h0, dn});
        pins(1, 2'b01);
        host.send_word(24'h100004, 1'b1);
        power_cycle();
        pins(4, 2'b11);
        check("precise early", 32'h0, {31'h0, lock});
        pins(2, 2'b11);
        check("precise lock", 32'h1, {31'h0, lock});
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_bus();
        t_latches();
        t_power();
        t_divider();
        t_lock();
        finish_test();
    end
endmodule // pll_divider_serial_config_tb
